// file: core/mem_protect_cfg.svh
// Address map, field positions, sizes and reset values of the memory protection block
`ifndef MEM_PROTECT_CFG_SVH
`define MEM_PROTECT_CFG_SVH
`define DATA_W        64
`define ECC_W         8
`define RAM_AW        12
`define FLM_AW        5
`define FLD_AW        4
`define PRAM_AW       5
`define FLD_BASE      12'hF02
`define FLM_BASE      12'h000
`define PMC_EXPORT    4
`define CHK_INSTR     0
`define CHK_BANK0     1
`define CHK_BANK1     2
`define OFF_CTRL      8'h00
`define OFF_STATUS    8'h04
`define OFF_SERR_ADDR 8'h08
`define OFF_MERR_ADDR 8'h0C
`define OFF_PAR_ADDR  8'h10
`define OFF_INIT_CTRL 8'h14
`define OFF_INIT_SEL  8'h18
`define OFF_FAULT     8'h1C
`define OFF_FL_ADDR   8'h20
`define OFF_FL_WLO    8'h24
`define OFF_FL_WHI    8'h28
`define OFF_FL_PROG   8'h2C
`define OFF_PR_ADDR   8'h30
`define OFF_PR_DATA   8'h34
`define CTRL_PAR_EN   0
`define CTRL_PAR_ODD  1
`define CTRL_PAR_IRQ  2
`define CTRL_SERR_IRQ 3
`define CTRL_MERR_IRQ 4
`define ST_SERR       0
`define ST_MERR       1
`define ST_APAR       2
`define ST_DEC        3
`define ST_PAR        4
`define ST_INIT_DONE  5
`define SEL_RAM       0
`define SEL_PRAM      1
`define FL_SEL_DATA   31
`define CTRL_RESET    32'h0000_0000
`endif

// file: core/mem_protect_pkg.sv
// Types and check-code arithmetic shared by both ends
package mem_protect_pkg;
	typedef enum logic [1:0] {INIT_IDLE, INIT_RUN, INIT_DONE} init_state_t;
	typedef logic [63:0] word_t;
	typedef logic [7:0] ecc_t;

	// Column of the check matrix for data bit j; top bit set keeps it off the unit vectors
	function automatic ecc_t ecc_col(input int unsigned j);
		logic [6:0] low;
		low = 7'(j + 8);
		return {1'b1, low};
	endfunction

	// Check code over one 64-bit group
	function automatic ecc_t ecc_code(input word_t d);
		ecc_t c;
		c = 8'h00;
		for (int unsigned j = 0; j < 64; j++) begin
			if (d[j]) begin
				c = c ^ ecc_col(j);
			end
		end
		return c;
	endfunction
endpackage

// file: core/coupled_mem_if.sv
// Tightly coupled memory ports and event bus between core and memory side
interface coupled_mem_if;
	// Instruction port (flash)
	logic        i_req;
	logic [31:0] i_addr;
	logic        i_valid;
	logic        i_abort;
	logic [63:0] i_rdata;
	logic [7:0]  i_recc;
	// Data port (RAM)
	logic        d_req;
	logic        d_we;
	logic [11:0] d_addr;
	logic        d_addr_par;
	logic [63:0] d_wdata;
	logic [7:0]  d_wecc;
	logic        d_ready;
	logic        d_valid;
	logic [63:0] d_rdata;
	logic [7:0]  d_recc;
	// Event bus
	logic        ev_single;
	logic        ev_multi;
	logic        ev_data_port;

	modport device (
		input  i_req, i_addr, d_req, d_we, d_addr, d_addr_par, d_wdata, d_wecc,
		input  ev_single, ev_multi, ev_data_port,
		output i_valid, i_abort, i_rdata, i_recc, d_ready, d_valid, d_rdata, d_recc
	);
	modport core (
		output i_req, i_addr, d_req, d_we, d_addr, d_addr_par, d_wdata, d_wecc,
		output ev_single, ev_multi, ev_data_port,
		input  i_valid, i_abort, i_rdata, i_recc, d_ready, d_valid, d_rdata, d_recc
	);
endinterface

// file: core/memory_protection_device.sv
// Flash check-code path, RAM ECC wrapper and peripheral RAM parity with APB registers
`include "mem_protect_cfg.svh"
module memory_protection_device (
	// System
	input  wire logic        CLK,
	input  wire logic        NRST,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [31:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Error signals
	output logic             SERR_IRQ,
	output logic             MERR_IRQ,
	output logic             PAR_ERR,
	output logic             PAR_IRQ,
	// Core ports
	coupled_mem_if.device    cm
);
	// Storage arrays
	logic [143:0] flash_main [2**`FLM_AW];
	logic [71:0]  flash_data [2**`FLD_AW];
	logic [35:0]  bank0      [2**`RAM_AW];
	logic [35:0]  bank1      [2**`RAM_AW];
	logic [32:0]  pram       [2**`PRAM_AW];

	// Control and status registers
	logic [31:0] ctrl_q, ctrl_d, stat_q, stat_d;
	logic [31:0] serr_a_q, serr_a_d, merr_a_q, merr_a_d, par_a_q, par_a_d;
	logic [31:0] ini_c_q, ini_c_d, ini_s_q, ini_s_d, fault_q, fault_d;
	logic [31:0] fl_a_q, fl_a_d, fl_lo_q, fl_lo_d, fl_hi_q, fl_hi_d, pr_a_q, pr_a_d;
	logic [31:0] prdata_d;
	logic        pready_d, pslverr_d, par_err_d;
	logic [11:0] last_rd_q, last_rd_d;
	mem_protect_pkg::init_state_t ini_st_q, ini_st_d;
	logic [11:0] ini_cnt_q, ini_cnt_d;

	logic        wr, rd, mapped;
	logic [7:0]  off;
	logic [32:0] pr_word;
	logic        pr_bad;
	logic [31:0] set, clr;

	// Duplicated decode; both copies are kept so a fault in one is visible
	function automatic logic ram_sel(input logic req, input logic [11:0] a, input logic p);
		return req & ~(^{a, p});
	endfunction
	logic cs_a, cs_b, ecc_sel_a, ecc_sel_b, d_ok;
	assign cs_a      = ram_sel(cm.d_req, cm.d_addr, cm.d_addr_par);
	assign cs_b      = ram_sel(cm.d_req, cm.d_addr, cm.d_addr_par);
	assign ecc_sel_a = ram_sel(cm.d_req, cm.d_addr, cm.d_addr_par);
	assign ecc_sel_b = ram_sel(cm.d_req, cm.d_addr, cm.d_addr_par);
	assign d_ok      = cs_a & cs_b & ecc_sel_a & ecc_sel_b & cm.d_ready;

	// Bus decode; the access completes on the cycle PREADY is seen high
	assign wr      = PSEL & PENABLE & PWRITE & PREADY;
	assign rd      = PSEL & PENABLE & ~PWRITE & PREADY;
	assign off     = PADDR[7:0];
	assign mapped  = (PADDR[31:8] == 24'h00_0000) && (off[1:0] == 2'b00) && (off <= `OFF_PR_DATA);
	assign pr_word = pram[pr_a_q[`PRAM_AW-1:0]];
	assign pr_bad  = ctrl_q[`CTRL_PAR_EN] & ((^pr_word) ^ ctrl_q[`CTRL_PAR_ODD]);

	// Register next values, flags and init sequencer
	always_comb begin
		ctrl_d = ctrl_q; fault_d = fault_q; ini_c_d = ini_c_q; ini_s_d = ini_s_q;
		fl_a_d = fl_a_q; fl_lo_d = fl_lo_q; fl_hi_d = fl_hi_q; pr_a_d = pr_a_q;
		serr_a_d = serr_a_q; merr_a_d = merr_a_q; par_a_d = par_a_q;
		last_rd_d = last_rd_q; ini_st_d = ini_st_q; ini_cnt_d = ini_cnt_q;
		set = 32'h0000_0000;
		clr = 32'h0000_0000;
		if (wr) begin
			case (off)
				`OFF_CTRL:      ctrl_d  = PWDATA;
				`OFF_STATUS:    clr     = PWDATA;
				`OFF_INIT_CTRL: ini_c_d = PWDATA;
				`OFF_INIT_SEL:  ini_s_d = PWDATA;
				`OFF_FAULT:     fault_d = PWDATA;
				`OFF_FL_ADDR:   fl_a_d  = PWDATA;
				`OFF_FL_WLO:    fl_lo_d = PWDATA;
				`OFF_FL_WHI:    fl_hi_d = PWDATA;
				`OFF_PR_ADDR:   pr_a_d  = PWDATA;
				default:        ;
			endcase
		end
		// Peripheral parity; data still goes back to the reader
		par_err_d = rd && off == `OFF_PR_DATA && pr_bad;
		if (par_err_d) begin
			set[`ST_PAR] = 1'b1;
			if (!stat_q[`ST_PAR] || clr[`ST_PAR]) begin
				par_a_d = pr_a_q;
			end
		end
		if (cm.d_req && cm.d_ready && !(cs_a && cs_b)) begin
			set[`ST_APAR] = 1'b1;
		end
		if ((cs_a ^ cs_b) || (ecc_sel_a ^ ecc_sel_b)) begin
			set[`ST_DEC] = 1'b1;
		end
		if (d_ok && !cm.d_we) begin
			last_rd_d = cm.d_addr;
		end
		// Event bus monitor; only data-port events belong to the RAM
		if (cm.ev_single && cm.ev_data_port) begin
			set[`ST_SERR] = 1'b1;
			if (!stat_q[`ST_SERR] || clr[`ST_SERR]) begin
				serr_a_d = {20'h0_0000, last_rd_q};
			end
		end
		if (cm.ev_multi && cm.ev_data_port) begin
			set[`ST_MERR] = 1'b1;
			if (!stat_q[`ST_MERR] || clr[`ST_MERR]) begin
				merr_a_d = {20'h0_0000, last_rd_q};
			end
		end
		// Init sequencer walks every RAM word once
		case (ini_st_q)
			mem_protect_pkg::INIT_IDLE: begin
				if (ini_c_q[0] && ini_s_q[1:0] != 2'b00) begin
					ini_st_d  = mem_protect_pkg::INIT_RUN;
					ini_cnt_d = 12'h000;
				end
			end
			mem_protect_pkg::INIT_RUN: begin
				ini_cnt_d = ini_cnt_q + 12'h001;
				if (ini_cnt_q == 12'hFFF) begin
					ini_st_d = mem_protect_pkg::INIT_DONE;
					set[`ST_INIT_DONE] = 1'b1;
				end
			end
			mem_protect_pkg::INIT_DONE: begin
				if (!ini_c_q[0]) begin
					ini_st_d = mem_protect_pkg::INIT_IDLE;
				end
			end
			default: ini_st_d = mem_protect_pkg::INIT_IDLE;
		endcase
		stat_d = (stat_q & ~clr) | set;
	end

	// Read mux and handshake
	always_comb begin
		prdata_d  = 32'h0000_0000;
		pready_d  = PSEL & PENABLE & ~PREADY;
		pslverr_d = PSEL & PENABLE & ~PREADY & ~mapped;
		case (off)
			`OFF_CTRL:      prdata_d = ctrl_q;
			`OFF_STATUS:    prdata_d = stat_q;
			`OFF_SERR_ADDR: prdata_d = serr_a_q;
			`OFF_MERR_ADDR: prdata_d = merr_a_q;
			`OFF_PAR_ADDR:  prdata_d = par_a_q;
			`OFF_INIT_CTRL: prdata_d = ini_c_q;
			`OFF_INIT_SEL:  prdata_d = ini_s_q;
			`OFF_FAULT:     prdata_d = fault_q;
			`OFF_FL_ADDR:   prdata_d = fl_a_q;
			`OFF_FL_WLO:    prdata_d = fl_lo_q;
			`OFF_FL_WHI:    prdata_d = fl_hi_q;
			`OFF_PR_ADDR:   prdata_d = pr_a_q;
			`OFF_PR_DATA:   prdata_d = pr_word[31:0];
			default:        prdata_d = 32'h0000_0000;
		endcase
		if (!mapped || PWRITE) begin
			prdata_d = 32'h0000_0000;
		end
	end

	// Register stage
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ctrl_q <= `CTRL_RESET; stat_q <= 32'h0000_0000; fault_q <= 32'h0000_0000;
			serr_a_q <= 32'h0000_0000; merr_a_q <= 32'h0000_0000; par_a_q <= 32'h0000_0000;
			ini_c_q <= 32'h0000_0000; ini_s_q <= 32'h0000_0000; fl_a_q <= 32'h0000_0000;
			fl_lo_q <= 32'h0000_0000; fl_hi_q <= 32'h0000_0000; pr_a_q <= 32'h0000_0000;
			last_rd_q <= 12'h000; ini_st_q <= mem_protect_pkg::INIT_IDLE; ini_cnt_q <= 12'h000;
			PRDATA <= 32'h0000_0000; PREADY <= 1'b0; PSLVERR <= 1'b0;
			SERR_IRQ <= 1'b0; MERR_IRQ <= 1'b0; PAR_ERR <= 1'b0; PAR_IRQ <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d; stat_q <= stat_d; fault_q <= fault_d;
			serr_a_q <= serr_a_d; merr_a_q <= merr_a_d; par_a_q <= par_a_d;
			ini_c_q <= ini_c_d; ini_s_q <= ini_s_d; fl_a_q <= fl_a_d;
			fl_lo_q <= fl_lo_d; fl_hi_q <= fl_hi_d; pr_a_q <= pr_a_d;
			last_rd_q <= last_rd_d; ini_st_q <= ini_st_d; ini_cnt_q <= ini_cnt_d;
			PRDATA <= prdata_d; PREADY <= pready_d; PSLVERR <= pslverr_d;
			SERR_IRQ <= stat_d[`ST_SERR] & ctrl_d[`CTRL_SERR_IRQ];
			MERR_IRQ <= stat_d[`ST_MERR] & ctrl_d[`CTRL_MERR_IRQ];
			PAR_ERR  <= par_err_d;
			PAR_IRQ  <= stat_d[`ST_PAR] & ctrl_d[`CTRL_PAR_IRQ];
		end
	end

	// Memory arrays carry no reset; contents come from init or programming
	logic [7:0]  prog_ecc;
	logic [63:0] prog_word;
	logic        ini_ram, ini_pram;
	assign prog_word = {fl_hi_q, fl_lo_q};
	assign prog_ecc  = mem_protect_pkg::ecc_code(prog_word) ^ fault_q[7:0];
	assign ini_ram   = ini_st_q == mem_protect_pkg::INIT_RUN && ini_s_q[`SEL_RAM];
	assign ini_pram  = ini_st_q == mem_protect_pkg::INIT_RUN && ini_s_q[`SEL_PRAM]
		&& ini_cnt_q < 12'(2**`PRAM_AW);
	always_ff @(posedge CLK) begin
		// Programming runs on its own path, so fetches carry on meanwhile
		if (wr && off == `OFF_FL_PROG) begin
			if (fl_a_q[`FL_SEL_DATA]) begin
				flash_data[fl_a_q[`FLD_AW-1:0]] <= {prog_ecc, prog_word};
			end else if (fl_a_q[0]) begin
				flash_main[fl_a_q[`FLM_AW:1]][143:72] <= {prog_ecc, prog_word};
			end else begin
				flash_main[fl_a_q[`FLM_AW:1]][71:0] <= {prog_ecc, prog_word};
			end
		end
		// Both banks share one write condition; each takes its half of the word and code
		if (ini_ram) begin
			bank0[ini_cnt_q] <= {4'h0, 32'h0000_0000};
			bank1[ini_cnt_q] <= {4'h0, 32'h0000_0000};
		end else if (d_ok && cm.d_we) begin
			// Fault bits spoil the stored code, so the event path can be exercised
			bank0[cm.d_addr] <= {cm.d_wecc[3:0] ^ fault_q[3:0], cm.d_wdata[55:48],
				cm.d_wdata[39:32], cm.d_wdata[23:16], cm.d_wdata[7:0]};
			bank1[cm.d_addr] <= {cm.d_wecc[7:4] ^ fault_q[7:4], cm.d_wdata[63:56],
				cm.d_wdata[47:40], cm.d_wdata[31:24], cm.d_wdata[15:8]};
		end
		if (ini_pram) begin
			pram[ini_cnt_q[`PRAM_AW-1:0]] <= {ctrl_q[`CTRL_PAR_ODD], 32'h0000_0000};
		end else if (wr && off == `OFF_PR_DATA) begin
			pram[pr_a_q[`PRAM_AW-1:0]] <= {(^PWDATA) ^ ctrl_q[`CTRL_PAR_ODD] ^ fault_q[8],
				PWDATA};
		end
	end

	// Core-facing answers, one cycle after the request
	logic        fetch_main, fetch_ok;
	logic [71:0] fetch_half;
	assign fetch_main = cm.i_addr[31:20] == `FLM_BASE && cm.i_addr[19:`FLM_AW+4] == '0;
	assign fetch_ok   = fetch_main && cm.i_addr[31:20] != `FLD_BASE;
	assign fetch_half = cm.i_addr[3] ? flash_main[cm.i_addr[`FLM_AW+3:4]][143:72]
		: flash_main[cm.i_addr[`FLM_AW+3:4]][71:0];
	logic [35:0] b0_rd, b1_rd;
	assign b0_rd = bank0[cm.d_addr];
	assign b1_rd = bank1[cm.d_addr];
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			cm.i_valid <= 1'b0; cm.i_abort <= 1'b0;
			cm.i_rdata <= 64'h0000_0000_0000_0000; cm.i_recc <= 8'h00;
			cm.d_valid <= 1'b0; cm.d_ready <= 1'b0;
			cm.d_rdata <= 64'h0000_0000_0000_0000; cm.d_recc <= 8'h00;
		end else begin
			cm.i_valid <= cm.i_req & fetch_ok;
			cm.i_abort <= cm.i_req & ~fetch_ok;
			cm.i_rdata <= fetch_half[63:0];
			cm.i_recc  <= fetch_half[71:64];
			cm.d_valid <= d_ok & ~cm.d_we;
			cm.d_ready <= ini_st_d != mem_protect_pkg::INIT_RUN;
			cm.d_rdata <= {b1_rd[31:24], b0_rd[31:24], b1_rd[23:16], b0_rd[23:16],
				b1_rd[15:8], b0_rd[15:8], b1_rd[7:0], b0_rd[7:0]};
			cm.d_recc  <= {b1_rd[35:32], b0_rd[35:32]};
		end
	end
endmodule

// file: core/processor_core_end.sv
// Processor-side end: drives the ports, checks codes and reports events
`include "mem_protect_cfg.svh"
module processor_core_end (
	// System
	input  wire logic        CLK,
	input  wire logic        NRST,
	// Fetch request and answer
	input  wire logic        FETCH_REQ,
	input  wire logic [31:0] FETCH_ADDR,
	output logic             FETCH_VALID,
	output logic             FETCH_ABORT,
	output logic      [63:0] FETCH_DATA,
	output logic             FETCH_SERR,
	output logic             FETCH_MERR,
	// Data request and answer
	input  wire logic        DATA_REQ,
	input  wire logic        DATA_WE,
	input  wire logic [11:0] DATA_ADDR,
	input  wire logic [63:0] DATA_WDATA,
	output logic             DATA_READY,
	output logic             DATA_VALID,
	output logic      [63:0] DATA_RDATA,
	output logic             DATA_SERR,
	output logic             DATA_MERR,
	// Control
	input  wire logic        PMC_WR,
	input  wire logic [31:0] PMC_DATA,
	input  wire logic [2:0]  CHECK_EN,
	// Memory side
	coupled_mem_if.core      cm
);
	logic [31:0] pmc_q, pmc_d;
	logic        i_chk, d_chk;
	logic [63:0] i_fix, d_fix;
	logic        i_s, i_m, d_s, d_m;
	logic        d_bank_q, d_bank_d;

	// Syndrome decode: a matching column flips that bit, a one-bit syndrome counts as single, other nonzero is multibit
	function automatic logic [65:0] check(input logic [63:0] d, input logic [7:0] e);
		logic [7:0]  syn;
		logic [63:0] fixd;
		logic        hit;
		syn  = mem_protect_pkg::ecc_code(d) ^ e;
		fixd = d;
		hit  = 1'b0;
		for (int unsigned j = 0; j < 64; j++) begin
			if (syn == mem_protect_pkg::ecc_col(j)) begin
				fixd[j] = ~d[j];
				hit     = 1'b1;
			end
		end
		if ($countones(syn) == 1) begin
			hit = 1'b1;
		end
		return {hit, syn != 8'h00 && !hit, fixd};
	endfunction

	// Check enables pick the port and the bank
	assign i_chk = CHECK_EN[`CHK_INSTR];
	assign d_chk = d_bank_q ? CHECK_EN[`CHK_BANK1] : CHECK_EN[`CHK_BANK0];
	assign {i_s, i_m, i_fix} = i_chk ? check(cm.i_rdata, cm.i_recc) : {2'b00, cm.i_rdata};
	assign {d_s, d_m, d_fix} = d_chk ? check(cm.d_rdata, cm.d_recc) : {2'b00, cm.d_rdata};

	// Control register next value
	always_comb begin
		pmc_d    = PMC_WR ? PMC_DATA : pmc_q;
		d_bank_d = (DATA_REQ && cm.d_ready) ? DATA_ADDR[0] : d_bank_q;
	end

	// Register stage; data requests are taken only while the memory side is ready
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			pmc_q <= 32'h0000_0000; d_bank_q <= 1'b0;
			cm.i_req <= 1'b0; cm.i_addr <= 32'h0000_0000;
			cm.d_req <= 1'b0; cm.d_we <= 1'b0; cm.d_addr <= 12'h000; cm.d_addr_par <= 1'b0;
			cm.d_wdata <= 64'h0000_0000_0000_0000; cm.d_wecc <= 8'h00;
			cm.ev_single <= 1'b0; cm.ev_multi <= 1'b0; cm.ev_data_port <= 1'b0;
			FETCH_VALID <= 1'b0; FETCH_ABORT <= 1'b0; FETCH_DATA <= 64'h0000_0000_0000_0000;
			FETCH_SERR <= 1'b0; FETCH_MERR <= 1'b0; DATA_READY <= 1'b0; DATA_VALID <= 1'b0;
			DATA_RDATA <= 64'h0000_0000_0000_0000; DATA_SERR <= 1'b0; DATA_MERR <= 1'b0;
		end else begin
			pmc_q <= pmc_d; d_bank_q <= d_bank_d;
			cm.i_req <= FETCH_REQ; cm.i_addr <= FETCH_ADDR;
			cm.d_req <= DATA_REQ & cm.d_ready;
			cm.d_we <= DATA_WE; cm.d_addr <= DATA_ADDR;
			cm.d_addr_par <= ^DATA_ADDR;
			cm.d_wdata <= DATA_WDATA;
			cm.d_wecc <= mem_protect_pkg::ecc_code(DATA_WDATA);
			// Single and multibit events leave only when export is on, ev_data_port is not gated; data port wins a same-cycle clash
			cm.ev_single <= pmc_q[`PMC_EXPORT] & ((cm.i_valid & i_s) | (cm.d_valid & d_s));
			cm.ev_multi  <= pmc_q[`PMC_EXPORT] & ((cm.i_valid & i_m) | (cm.d_valid & d_m));
			cm.ev_data_port <= cm.d_valid & (d_s | d_m);
			FETCH_VALID <= cm.i_valid; FETCH_ABORT <= cm.i_abort; FETCH_DATA <= i_fix;
			FETCH_SERR <= cm.i_valid & i_s; FETCH_MERR <= cm.i_valid & i_m;
			DATA_READY <= cm.d_ready; DATA_VALID <= cm.d_valid; DATA_RDATA <= d_fix;
			DATA_SERR <= cm.d_valid & d_s; DATA_MERR <= cm.d_valid & d_m;
		end
	end
endmodule

// file: verification/mem_protect_checker.sv
// Timing checks on the coupled memory interface between both ends
module mem_protect_checker (
	// System
	input wire logic        CLK,
	input wire logic        NRST,
	// Fetch port
	input wire logic        i_req,
	input wire logic [31:0] i_addr,
	input wire logic        i_valid,
	input wire logic        i_abort,
	// Data port
	input wire logic        d_req,
	input wire logic        d_we,
	input wire logic [11:0] d_addr,
	input wire logic        d_addr_par,
	input wire logic        d_ready,
	input wire logic        d_valid,
	// Event bus
	input wire logic        ev_single,
	input wire logic        ev_data_port
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	// Fetch answers: one kind, next cycle, never unasked
	fetch_answer_a: assert property (i_req |=> i_valid != i_abort)
		else $error("fetch got no single answer");
	fetch_cause_a: assert property ((i_valid || i_abort) |-> $past(i_req))
		else $error("fetch answer without request");
	no_exec_a: assert property (i_req && i_addr[31:20] == 12'hF02 |=> i_abort)
		else $error("fetch from data flash not aborted");
	main_fetch_a: assert property (i_req && i_addr[31:9] == 23'h00_0000 |=> i_valid)
		else $error("main flash fetch not served");
	// Address integrity and read answers on the data port
	addr_par_a: assert property (d_req |-> d_addr_par == ^d_addr)
		else $error("address parity wrong");
	read_answer_a: assert property (d_req && !d_we && d_ready |=> d_valid)
		else $error("accepted read not answered");
	read_cause_a: assert property (d_valid |-> $past(d_req) && !$past(d_we))
		else $error("read answer without read");
	// Auto-init keeps the port closed; events follow read answers
	init_block_a: assert property (!d_ready |=> !d_valid)
		else $error("access served during init");
	event_src_a: assert property (ev_single && ev_data_port |-> $past(d_valid))
		else $error("data event without read");
	cover property (i_req && i_addr[31:20] == 12'hF02);
	cover property (d_req && !d_we ##1 d_valid);
	cover property ($fell(d_ready));
endmodule

// file: verification/memory_ecc_parity_protection_bench.sv
// Both ends joined, driven from their user sides and checked
`include "mem_protect_cfg.svh"
module memory_ecc_parity_protection_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// Stimulus, observed outputs and bookkeeping
	logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = '0, pwdata = '0, f_addr = '0, pmc_data = '0, prdata, rdat, fa;
	logic        f_req = 1'b0, d_req = 1'b0, d_we = 1'b0, pmc_wr = 1'b0, rerr;
	logic [11:0] d_addr = '0;
	logic [63:0] d_wdata = '0, f_data, d_rdata, wd;
	logic [2:0]  chk_en = 3'b000;
	logic        pready, pslverr, serr_irq, merr_irq, par_err, par_irq;
	logic        f_valid, f_abort, f_serr, f_merr, d_ready, d_valid, d_serr, d_merr;
	logic [31:0] rnd = 32'h0000_0034;
	logic [7:0]  flt [4] = '{8'h00, 8'h01, 8'h03, 8'h03};
	int          errors = 0, num_checks = 0, par_cnt = 0;
	coupled_mem_if cm_bus ();
	memory_protection_device i_memory_protection_device (
		.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .SERR_IRQ(serr_irq), .MERR_IRQ(merr_irq),
		.PAR_ERR(par_err), .PAR_IRQ(par_irq), .cm(cm_bus.device));
	processor_core_end i_processor_core_end (
		.CLK(clk), .NRST(nrst), .FETCH_REQ(f_req), .FETCH_ADDR(f_addr),
		.FETCH_VALID(f_valid), .FETCH_ABORT(f_abort), .FETCH_DATA(f_data),
		.FETCH_SERR(f_serr), .FETCH_MERR(f_merr), .DATA_REQ(d_req), .DATA_WE(d_we),
		.DATA_ADDR(d_addr), .DATA_WDATA(d_wdata), .DATA_READY(d_ready),
		.DATA_VALID(d_valid), .DATA_RDATA(d_rdata), .DATA_SERR(d_serr),
		.DATA_MERR(d_merr), .PMC_WR(pmc_wr), .PMC_DATA(pmc_data), .CHECK_EN(chk_en),
		.cm(cm_bus.core));
	mem_protect_checker i_mem_protect_checker (
		.CLK(clk), .NRST(nrst), .i_req(cm_bus.i_req), .i_addr(cm_bus.i_addr),
		.i_valid(cm_bus.i_valid), .i_abort(cm_bus.i_abort), .d_req(cm_bus.d_req),
		.d_we(cm_bus.d_we), .d_addr(cm_bus.d_addr), .d_addr_par(cm_bus.d_addr_par),
		.d_ready(cm_bus.d_ready), .d_valid(cm_bus.d_valid),
		.ev_single(cm_bus.ev_single), .ev_data_port(cm_bus.ev_data_port));

	// Free-running clock
	initial begin
		forever #2 clk = ~clk;
	end
	// Parity pulses are one cycle wide, so count them as they pass
	always @(posedge clk) begin
		if (par_err === 1'b1)
			par_cnt++;
	end

	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Flags expected for a code fault: one bit corrects, more only flag
	function automatic logic [1:0] flags(input logic [7:0] f, input logic en);
		if (!en || f == 8'h00)
			return 2'b00;
		return ($countones(f) == 1) ? 2'b10 : 2'b01;
	endfunction

	task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic finish_test();
		if (errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// One APB transfer; entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h00_0000, a};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Waits for the answer however long; only the watchdog ends a hang
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic fetch(input logic [31:0] a);
		f_req <= 1'b1;
		f_addr <= a;
		@(posedge clk);
		f_req <= 1'b0;
		do begin
			@(posedge clk);
		end while (f_valid !== 1'b1 && f_abort !== 1'b1);
	endtask
	// A write lets one edge pass so the next call never re-raises the request at once
	task automatic dport(input logic w, input logic [11:0] a, input logic [63:0] d);
		d_req <= 1'b1;
		d_we <= w;
		d_addr <= a;
		d_wdata <= d;
		@(posedge clk);
		d_req <= 1'b0;
		do begin
			@(posedge clk);
		end while (!w && d_valid !== 1'b1);
	endtask

	// Hang guard, sized well beyond init plus traffic
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		finish_test();
	end

	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		pmc_wr <= 1'b1;
		pmc_data <= 32'h0000_0010;
		chk_en <= 3'b111;
		apb(1'b0, `OFF_CTRL, 32'h0000_0000);
		pmc_wr <= 1'b0;
		chk("ctrl reset", 64'(rdat), 64'h0);
		apb(1'b0, 8'h38, 32'h0000_0000);
		chk("unmapped", 64'(rerr), 64'h1);
		// Auto-init of both memories; port stays closed meanwhile
		apb(1'b1, `OFF_INIT_SEL, 32'h0000_0003);
		apb(1'b1, `OFF_INIT_CTRL, 32'h0000_0001);
		repeat (4) @(posedge clk);
		chk("ready in init", 64'(d_ready), 64'h0);
		rdat = '0;
		for (int i = 0; i < 2000 && rdat[`ST_INIT_DONE] !== 1'b1; i++)
			apb(1'b0, `OFF_STATUS, 32'h0000_0000);
		chk("init done", 64'(rdat[`ST_INIT_DONE]), 64'h1);
		dport(1'b0, 12'h005, 64'h0);
		chk("init word", d_rdata, 64'h0);
		chk("init flags", 64'({d_serr, d_merr}), 64'h0);
		// RAM write and read back, edges of the address range first
		for (int i = 0; i < 8; i++) begin
			rnd = step(rnd);
			wd = {rnd, step(rnd)};
			d_addr <= (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : rnd[11:0];
			@(posedge clk);
			dport(1'b1, d_addr, wd);
			dport(1'b0, d_addr, 64'h0);
			chk("ram data", d_rdata, wd);
			chk("ram flags", 64'({d_serr, d_merr}), 64'h0);
		end
		// Flash groups with faulted codes, checking on and off
		for (int i = 0; i < 4; i++) begin
			rnd = step(rnd);
			fa = 32'(2 * i + i % 2);
			chk_en <= (i == 3) ? 3'b110 : 3'b111;
			apb(1'b1, `OFF_FAULT, {24'h00_0000, flt[i]});
			apb(1'b1, `OFF_FL_ADDR, fa);
			apb(1'b1, `OFF_FL_WLO, rnd);
			apb(1'b1, `OFF_FL_WHI, ~rnd);
			apb(1'b1, `OFF_FL_PROG, 32'h0000_0000);
			fetch(fa << 3);
			chk("fetch data", f_data, {~rnd, rnd});
			chk("fetch flags", 64'({f_serr, f_merr}), 64'(flags(flt[i], i != 3)));
		end
		apb(1'b1, `OFF_FAULT, 32'h0000_0000);
		apb(1'b1, `OFF_FL_ADDR, 32'h8000_0002);
		apb(1'b1, `OFF_FL_PROG, 32'h0000_0000);
		chk("data flash prog", 64'(rerr), 64'h0);
		fetch(32'hF020_0010);
		chk("data flash fetch", 64'({f_abort, f_valid}), 64'h2);
		// Peripheral word stored with bad parity, read off then on
		rnd = step(rnd);
		apb(1'b1, `OFF_PR_ADDR, 32'h0000_0007);
		apb(1'b1, `OFF_FAULT, 32'h0000_0100);
		apb(1'b1, `OFF_PR_DATA, rnd);
		apb(1'b0, `OFF_PR_DATA, 32'h0000_0000);
		chk("par off data", 64'(rdat), 64'(rnd));
		chk("par off", 64'(par_cnt), 64'h0);
		apb(1'b1, `OFF_CTRL, 32'h0000_0005);
		apb(1'b0, `OFF_PR_DATA, 32'h0000_0000);
		chk("par on data", 64'(rdat), 64'(rnd));
		apb(1'b0, `OFF_PAR_ADDR, 32'h0000_0000);
		chk("par addr", 64'(rdat), 64'h7);
		chk("par pulses", 64'(par_cnt), 64'h1);
		chk("par irq", 64'(par_irq), 64'h1);
		// Second failing word while the first is pending
		apb(1'b1, `OFF_PR_ADDR, 32'h0000_0009);
		apb(1'b1, `OFF_PR_DATA, ~rnd);
		apb(1'b1, `OFF_FAULT, 32'h0000_0000);
		apb(1'b0, `OFF_PR_DATA, 32'h0000_0000);
		apb(1'b0, `OFF_PAR_ADDR, 32'h0000_0000);
		chk("par addr held", 64'(rdat), 64'h7);
		apb(1'b1, `OFF_STATUS, 32'h0000_0010);
		repeat (2) @(posedge clk);
		chk("par irq clear", 64'(par_irq), 64'h0);
		chk("ram irqs", 64'({serr_irq, merr_irq}), 64'h0);
		// Spoiled RAM codes: single then multibit, events, addresses, interrupts
		apb(1'b1, `OFF_CTRL, 32'h0000_0018);
		for (int i = 1; i < 3; i++) begin
			apb(1'b1, `OFF_FAULT, 32'(2 * i - 1));
			dport(1'b1, 12'(12'h0A0 + i), wd);
			apb(1'b1, `OFF_FAULT, 32'h0000_0000);
			dport(1'b0, 12'(12'h0A0 + i), 64'h0);
			chk("fault data", d_rdata, wd);
			chk("fault flags", 64'({d_serr, d_merr}), 64'(flags(8'(2 * i - 1), 1'b1)));
			repeat (3) @(posedge clk);
		end
		apb(1'b0, `OFF_SERR_ADDR, 32'h0000_0000);
		chk("serr addr", 64'(rdat), 64'h0A1);
		apb(1'b0, `OFF_MERR_ADDR, 32'h0000_0000);
		chk("merr addr", 64'(rdat), 64'h0A2);
		chk("ram irqs set", 64'({serr_irq, merr_irq}), 64'h3);
		finish_test();
	end
endmodule
